// >>> src/pmd_pkg.sv
package pmd_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int RUN_STEP_MS = 1;
    // hibernate tick period in ms, i.e. a 100Hz slow clock
    localparam int HIB_TICK_MS = 10;
    localparam int MS_CYCLES = CLK_HZ / 1000 * RUN_STEP_MS;
    localparam int HIB_CYCLES = CLK_HZ / 1000 * HIB_TICK_MS;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_SENSOR_CONFIG = 7'h12;
    localparam logic [6:0] ADDR_RUN_TO_REST1_COUNT = 7'h13;
    localparam logic [6:0] ADDR_REST1_PERIOD = 7'h14;
    localparam logic [6:0] ADDR_REST1_TO_REST2_COUNT = 7'h15;
    localparam logic [6:0] ADDR_REST2_PERIOD = 7'h16;
    localparam logic [6:0] ADDR_REST2_TO_REST3_COUNT = 7'h17;
    localparam logic [6:0] ADDR_REST3_PERIOD = 7'h18;
    localparam int NUM_REGS = 7;

    localparam logic [7:0] RST_SENSOR_CONFIG = 8'h26;
    localparam logic [7:0] RST_RUN_TO_REST1_COUNT = 8'h04;
    localparam logic [7:0] RST_REST1_PERIOD = 8'h01;
    localparam logic [7:0] RST_REST1_TO_REST2_COUNT = 8'h1f;
    localparam logic [7:0] RST_REST2_PERIOD = 8'h09;
    localparam logic [7:0] RST_REST2_TO_REST3_COUNT = 8'h2f;
    localparam logic [7:0] RST_REST3_PERIOD = 8'h31;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // config fields: bit 7 and reserved bit 4 are not stored
    localparam logic [7:0] CONFIG_MASK = 8'h6f;
    localparam int CPI_LSB = 5;
    localparam int AWAKE_BIT = 3;
    localparam int RUN_RATE_LSB = 0;
    localparam logic [2:0] RUN_RATE_MAX = 3'h6;
    localparam logic [8:0] RUN_BASE_MS = 9'h002;

    // inactivity multipliers, in frames per count unit
    localparam logic [15:0] RUN_FRAMES_PER_UNIT = 16'h0008;
    localparam logic [15:0] REST1_FRAMES_PER_UNIT = 16'h0010;
    localparam logic [15:0] REST2_FRAMES_PER_UNIT = 16'h0080;

    // decoded resolution in counts per inch
    localparam logic [11:0] CPI_400 = 12'h190;
    localparam logic [11:0] CPI_800 = 12'h320;
    localparam logic [11:0] CPI_1200 = 12'h4b0;
    localparam logic [11:0] CPI_1600 = 12'h640;

    // serial frame: 8 address bits then 8 data bits
    localparam logic [4:0] SPI_ADDR_BITS = 5'h08;
    localparam logic [4:0] SPI_FRAME_BITS = 5'h10;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PM_RUN,
        PM_REST1,
        PM_REST2,
        PM_REST3
    } pmd_mode_e;

    typedef struct packed {
        logic ncs_n;
        logic sclk;
        logic mosi;
    } pmd_spi_s;

endpackage

// >>> src/pmd_tick_div.sv
`timescale 1ns/1ps

// free-running divider giving a one-cycle pulse every CYCLES clocks
module pmd_tick_div #(
    parameter int CYCLES = 10
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // tick
    output logic tick_o
);
    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    logic [W-1:0] cnt;

    // wrap counter; the pulse is registered so it is glitch free
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt <= '0;
            tick_o <= 1'b0;
        end else if (cnt == LAST) begin
            cnt <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt <= cnt + 1'b1;
            tick_o <= 1'b0;
        end
    end
endmodule

// >>> src/pmd_power_ctrl.sv
`timescale 1ns/1ps

module pmd_power_ctrl
    import pmd_pkg::*;
#(
    parameter int MS_TICK_CYCLES = MS_CYCLES,
    parameter int HIB_TICK_CYCLES = HIB_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // serial port
    input wire pmd_spi_s spi_i,
    output logic miso_o,
    output logic miso_oe_o,
    // motion and power state
    input wire logic motion_i,
    output pmd_mode_e power_mode_o,
    output logic frame_tick_o,
    // resolution
    output logic [1:0] cpi_select_o,
    output logic [11:0] cpi_value_o
);

    // ------------------------------------------------------------
    // serial slave
    // ------------------------------------------------------------
    logic sclk_q;
    logic sclk_rise;
    logic sclk_fall;
    logic [4:0] bit_cnt;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic [6:0] addr;
    logic is_write;
    logic wr_en;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic [7:0] regs [NUM_REGS];

    // pins are synchronous to clk, so a one-stage history gives the edges
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= spi_i.sclk;
        end
    end

    assign sclk_rise = spi_i.sclk & ~sclk_q & ~spi_i.ncs_n;
    assign sclk_fall = ~spi_i.sclk & sclk_q & ~spi_i.ncs_n;

    // receive: msb first, sampled on rising edge
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bit_cnt <= '0;
            rx_sh <= '0;
            addr <= '0;
            is_write <= 1'b0;
        end else if (spi_i.ncs_n) begin
            bit_cnt <= '0;
        end else if (sclk_rise) begin
            rx_sh <= {rx_sh[6:0], spi_i.mosi};
            if (bit_cnt == SPI_ADDR_BITS - 5'h01) begin
                is_write <= rx_sh[6];
                addr <= {rx_sh[5:0], spi_i.mosi};
            end
            // frames may follow back to back inside one select
            bit_cnt <= (bit_cnt == SPI_FRAME_BITS - 5'h01) ? 5'h00 : bit_cnt + 5'h01;
        end
    end

    assign wr_en = sclk_rise & is_write & (bit_cnt == SPI_FRAME_BITS - 5'h01);
    assign wr_data = {rx_sh[6:0], spi_i.mosi};

    // transmit: load after the address byte, shift on falling edges
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_sh <= '0;
            miso_oe_o <= 1'b0;
        end else if (spi_i.ncs_n) begin
            miso_oe_o <= 1'b0;
        end else if (sclk_fall) begin
            if (bit_cnt == SPI_ADDR_BITS && !is_write) begin
                tx_sh <= rd_data;
                miso_oe_o <= 1'b1;
            end else if (bit_cnt > SPI_ADDR_BITS) begin
                tx_sh <= {tx_sh[6:0], 1'b0};
            end else begin
                miso_oe_o <= 1'b0;
            end
        end
    end

    assign miso_o = tx_sh[7];

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic in_map;
    logic [2:0] idx;

    assign in_map = (addr >= ADDR_SENSOR_CONFIG) && (addr <= ADDR_REST3_PERIOD);
    assign idx = 3'(addr - ADDR_SENSOR_CONFIG);

    // unmapped writes are dropped; config keeps only its defined bits
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            regs[0] <= RST_SENSOR_CONFIG;
            regs[1] <= RST_RUN_TO_REST1_COUNT;
            regs[2] <= RST_REST1_PERIOD;
            regs[3] <= RST_REST1_TO_REST2_COUNT;
            regs[4] <= RST_REST2_PERIOD;
            regs[5] <= RST_REST2_TO_REST3_COUNT;
            regs[6] <= RST_REST3_PERIOD;
        end else if (wr_en && in_map) begin
            regs[idx] <= (idx == 3'h0) ? (wr_data & CONFIG_MASK) : wr_data;
        end
    end

    assign rd_data = in_map ? regs[idx] : UNMAPPED_READ;

    // ------------------------------------------------------------
    // configuration decode
    // ------------------------------------------------------------
    logic force_awake;
    logic [2:0] run_code;

    assign cpi_select_o = regs[0][CPI_LSB+:2];
    assign force_awake = regs[0][AWAKE_BIT];
    // code 7 is undefined; clamping keeps the period at the 8ms maximum
    assign run_code = (regs[0][RUN_RATE_LSB+:3] > RUN_RATE_MAX) ? RUN_RATE_MAX
                      : regs[0][RUN_RATE_LSB+:3];

    // decoded resolution, loaded by the same write as the select so the two never disagree
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cpi_value_o <= CPI_800;
        end else if (wr_en && in_map && idx == 3'h0) begin
            case (wr_data[CPI_LSB+:2])
                2'h0: cpi_value_o <= CPI_400;
                2'h1: cpi_value_o <= CPI_800;
                2'h2: cpi_value_o <= CPI_1200;
                default: cpi_value_o <= CPI_1600;
            endcase
        end
    end

    // ------------------------------------------------------------
    // frame timing
    // ------------------------------------------------------------
    logic ms_tick;
    logic hib_tick;
    logic base_tick;
    logic [8:0] period_ticks;
    logic [8:0] frame_cnt;
    logic mode_change;

    pmd_tick_div #(.CYCLES(MS_TICK_CYCLES)) u_ms_div (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .tick_o(ms_tick)
    );

    pmd_tick_div #(.CYCLES(HIB_TICK_CYCLES)) u_hib_div (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .tick_o(hib_tick)
    );

    // run counts 1ms ticks, rest modes count 10ms hibernate ticks
    always_comb begin
        case (power_mode_o)
            PM_RUN: begin
                base_tick = ms_tick;
                period_ticks = {6'h00, run_code} + RUN_BASE_MS;
            end
            PM_REST1: begin
                base_tick = hib_tick;
                period_ticks = {1'b0, regs[2]} + 9'h001;
            end
            PM_REST2: begin
                base_tick = hib_tick;
                period_ticks = {1'b0, regs[4]} + 9'h001;
            end
            default: begin
                base_tick = hib_tick;
                period_ticks = {1'b0, regs[6]} + 9'h001;
            end
        endcase
    end

    // frame period counter, restarted whenever the mode changes
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            frame_cnt <= '0;
            frame_tick_o <= 1'b0;
        end else if (mode_change) begin
            frame_cnt <= '0;
            frame_tick_o <= 1'b0;
        end else if (base_tick && (frame_cnt + 9'h001 >= period_ticks)) begin
            frame_cnt <= '0;
            frame_tick_o <= 1'b1;
        end else begin
            frame_cnt <= base_tick ? frame_cnt + 9'h001 : frame_cnt;
            frame_tick_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // power mode and inactivity
    // ------------------------------------------------------------
    logic [15:0] idle_frames;
    logic [15:0] idle_limit;
    pmd_mode_e next_mode;
    logic step_down;

    // frames without motion before stepping down from the present mode
    always_comb begin
        case (power_mode_o)
            PM_RUN: idle_limit = 16'({8'h00, regs[1]} * RUN_FRAMES_PER_UNIT);
            PM_REST1: idle_limit = 16'({8'h00, regs[3]} * REST1_FRAMES_PER_UNIT);
            PM_REST2: idle_limit = 16'({8'h00, regs[5]} * REST2_FRAMES_PER_UNIT);
            default: idle_limit = 16'h0000;
        endcase
    end

    // a zero count disables the step, so a cleared register holds the present mode
    assign step_down = frame_tick_o && !force_awake && (idle_limit != 16'h0000)
                       && (idle_frames + 16'h0001 >= idle_limit);

    // next mode: motion and force awake override the idle step
    always_comb begin
        next_mode = power_mode_o;
        if (motion_i || force_awake) begin
            next_mode = PM_RUN;
        end else if (step_down) begin
            case (power_mode_o)
                PM_RUN: next_mode = PM_REST1;
                PM_REST1: next_mode = PM_REST2;
                PM_REST2: next_mode = PM_REST3;
                default: next_mode = PM_REST3;
            endcase
        end
    end

    assign mode_change = (next_mode != power_mode_o);

    // mode register and idle frame counter
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            power_mode_o <= PM_RUN;
            idle_frames <= '0;
        end else begin
            power_mode_o <= next_mode;
            if (motion_i || mode_change) begin
                idle_frames <= '0;
            end else if (frame_tick_o && idle_frames != 16'hffff) begin
                idle_frames <= idle_frames + 16'h0001;
            end
        end
    end

endmodule

// >>> tb/pmd_power_ctrl_checker.sv
`timescale 1ns/1ps

module pmd_power_ctrl_checker
    import pmd_pkg::*;
#(
    parameter int MS_TICK_CYCLES = MS_CYCLES,
    parameter int HIB_TICK_CYCLES = HIB_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // watched ports
    input wire pmd_spi_s spi_i,
    input wire logic miso_o,
    input wire logic miso_oe_o,
    input wire logic motion_i,
    input wire pmd_mode_e power_mode_o,
    input wire logic frame_tick_o,
    input wire logic [1:0] cpi_select_o,
    input wire logic [11:0] cpi_value_o
);
    int gap_q;
    pmd_mode_e last_q;
    logic seen_q;

    // spacing since the previous tick; the first frame after reset is not judged
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gap_q <= 1;
            last_q <= PM_RUN;
            seen_q <= 1'b0;
        end else if (frame_tick_o) begin
            gap_q <= 1;
            last_q <= power_mode_o;
            seen_q <= 1'b1;
        end else begin
            gap_q <= gap_q + 1;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    cpi_map_a: assert property (cpi_value_o == 12'(12'h190 * (int'(cpi_select_o) + 1)))
        else $error("cpi value does not match select");
    reset_state_a: assert property ($rose(reset_n_i) |-> cpi_select_o == 2'h1
        && power_mode_o == PM_RUN) else $error("bad state after reset");
    motion_run_a: assert property (motion_i |=> power_mode_o == PM_RUN)
        else $error("motion did not return to run");
    step_order_a: assert property ($changed(power_mode_o) && power_mode_o != PM_RUN
        |-> 2'(power_mode_o - $past(power_mode_o)) == 2'h1) else $error("mode skipped");
    step_tick_a: assert property ($changed(power_mode_o) && power_mode_o != PM_RUN
        |-> $past(frame_tick_o) && !$past(motion_i)) else $error("step off frame");
    tick_pulse_a: assert property (frame_tick_o |=> !frame_tick_o)
        else $error("frame tick too long");
    run_grid_a: assert property (frame_tick_o && seen_q && last_q == PM_RUN
        && power_mode_o == PM_RUN |-> gap_q % MS_TICK_CYCLES == 0) else $error("run spacing");
    rest_grid_a: assert property (frame_tick_o && seen_q && last_q == power_mode_o
        && power_mode_o != PM_RUN |-> gap_q % HIB_TICK_CYCLES == 0) else $error("rest spacing");

    cover property (power_mode_o == PM_REST3);
    cover property (miso_oe_o);
    cover property (motion_i && power_mode_o != PM_RUN);
endmodule

bind pmd_power_ctrl pmd_power_ctrl_checker #(
    .MS_TICK_CYCLES(MS_TICK_CYCLES),
    .HIB_TICK_CYCLES(HIB_TICK_CYCLES)
) chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .spi_i(spi_i), .miso_o(miso_o),
    .miso_oe_o(miso_oe_o), .motion_i(motion_i), .power_mode_o(power_mode_o),
    .frame_tick_o(frame_tick_o), .cpi_select_o(cpi_select_o), .cpi_value_o(cpi_value_o));

// >>> tb/pmd_spi_host.sv
`timescale 1ns/1ps

// controller model; sclk idles low and stands still between frames
module pmd_spi_host
    import pmd_pkg::*;
(
    // clock
    input wire logic clk_i,
    // serial port
    output pmd_spi_s spi_o,
    input wire logic miso_i,
    input wire logic miso_oe_i
);
    initial spi_o = '{ncs_n: 1'b1, sclk: 1'b0, mosi: 1'b0};

    // one whole frame, msb first; never starts a self test, so the port stays usable
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [15:0] w;
        w = {a, d};
        @(posedge clk_i);
        #1 spi_o.ncs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            repeat (3) @(posedge clk_i);
            #1 spi_o.sclk = 1'b0;
            spi_o.mosi = w[i];
            repeat (3) @(posedge clk_i);
            #1 spi_o.sclk = 1'b1;
            // undriven miso must never pass as data
            if (i < 8) q[i] = miso_oe_i ? miso_i : 1'bx;
        end
        repeat (3) @(posedge clk_i);
        #1 spi_o.sclk = 1'b0;
        spi_o.mosi = ~spi_o.mosi;
        repeat (3) @(posedge clk_i);
        #1 spi_o.ncs_n = 1'b1;
    endtask
endmodule

// >>> tb/power_mode_downshift_control_bench.sv
`timescale 1ns/1ps

module power_mode_downshift_control_bench import pmd_pkg::*;;
    localparam int MS = 4;
    localparam int HIB = 8;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic motion_i = 1'b1;
    pmd_spi_s spi;
    logic miso;
    logic miso_oe;
    logic frame_tick;
    pmd_mode_e mode;
    logic [1:0] cpi_sel;
    logic [11:0] cpi_val;
    logic [7:0] q;
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int gap = 0;
    int tick_gap = 0;

    initial forever #50 clk_i = ~clk_i;

    pmd_power_ctrl #(.MS_TICK_CYCLES(MS), .HIB_TICK_CYCLES(HIB)) dut_u (.clk_i(clk_i),
        .reset_n_i(reset_n_i), .spi_i(spi), .miso_o(miso), .miso_oe_o(miso_oe),
        .motion_i(motion_i), .power_mode_o(mode), .frame_tick_o(frame_tick),
        .cpi_select_o(cpi_sel), .cpi_value_o(cpi_val));
    pmd_spi_host host_u (.clk_i(clk_i), .spi_o(spi), .miso_i(miso), .miso_oe_i(miso_oe));

    // frame spacing as seen at the pin, plus the hang guard
    always @(posedge clk_i) begin
        cyc++;
        gap++;
        if (frame_tick === 1'b1) begin
            tick_gap = gap;
            gap = 0;
        end
        if (cyc == 40000) begin
            err_count++;
            stop_test();
        end
    end

    task automatic chk(input logic [11:0] g, input logic [11:0] e);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask

    task automatic chk_rng(input int n, input int lo, input int hi);
        tests_run++;
        if (n < lo || n > hi) begin
            err_count++;
            $display("BAD %0t count %0d outside %0d..%0d", $time, n, lo, hi);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_u.xfer(a | 8'h80, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        host_u.xfer(a, 8'h00, q);
        chk({4'h0, q}, {4'h0, e});
    endtask

    // bounded so a stuck mode ends as a failed count, not a hang
    task automatic wait_mode(input pmd_mode_e m, output int n);
        n = 0;
        while (mode !== m && n < 5000) begin
            @(posedge clk_i);
            #1 n++;
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic t_reset();
        logic [7:0] exp [7] = '{8'h26, 8'h04, 8'h01, 8'h1f, 8'h09, 8'h2f, 8'h31};
        chk(cpi_val, 12'h320);
        chk({10'h0, mode}, 12'h000);
        for (int i = 0; i < 7; i++) rd_chk(8'h12 + 8'(i), exp[i]);
        rd_chk(8'h11, 8'h00);
        wr(8'h19, 8'h5a);
        rd_chk(8'h19, 8'h00);
    endtask

    // every resolution code; bit 7 never sticks
    task automatic t_cpi();
        for (int k = 0; k < 4; k++) begin
            wr(8'h12, {1'b0, 2'(k), 5'h0e});
            chk({10'h0, cpi_sel}, 12'(k));
            chk(cpi_val, 12'(12'h190 * (k + 1)));
        end
        wr(8'h12, 8'hff);
        rd_chk(8'h12, 8'h6f);
    endtask

    // forced awake so no step-down disturbs the spacing; code 7 is held at the 8ms period
    task automatic t_run();
        for (int c = 0; c < 8; c++) begin
            int p;
            p = ((c > 6) ? 6 : c) + 2;
            wr(8'h12, 8'h28 | 8'(c));
            repeat (100) @(posedge clk_i);
            #1 chk_rng(tick_gap, p * MS, p * MS);
        end
    endtask

    // distinct rest periods so a swapped register shows up
    task automatic t_down();
        int n;
        wr(8'h13, 8'h02);
        wr(8'h14, 8'h01);
        wr(8'h15, 8'h01);
        wr(8'h16, 8'h02);
        wr(8'h17, 8'h01);
        wr(8'h18, 8'h03);
        wr(8'h12, 8'h20);
        motion_i = 1'b0;
        wait_mode(PM_REST1, n);
        chk_rng(n, 15 * 2 * MS, 17 * 2 * MS);
        chk_rng(tick_gap, 2 * MS, 2 * MS);
        wait_mode(PM_REST2, n);
        chk_rng(n, 15 * 2 * HIB, 17 * 2 * HIB);
        chk_rng(tick_gap, 2 * HIB, 2 * HIB);
        wait_mode(PM_REST3, n);
        chk_rng(n, 127 * 3 * HIB, 129 * 3 * HIB);
        chk_rng(tick_gap, 3 * HIB, 3 * HIB);
        repeat (200) @(posedge clk_i);
        #1 chk_rng(tick_gap, 4 * HIB, 4 * HIB);
    endtask

    // a one-cycle motion pulse wakes from rest 3, then forced awake leaves rest 1
    task automatic t_wake();
        int n;
        motion_i = 1'b1;
        @(posedge clk_i);
        #1 motion_i = 1'b0;
        @(posedge clk_i);
        #1 chk({10'h0, mode}, 12'h000);
        wait_mode(PM_REST1, n);
        chk_rng(n, 15 * 2 * MS, 17 * 2 * MS);
        wr(8'h12, 8'h28);
        chk({10'h0, mode}, 12'h000);
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        #1 reset_n_i = 1'b1;
        @(posedge clk_i);
        #1 t_reset();
        t_cpi();
        t_run();
        t_down();
        t_wake();
        stop_test();
    end
endmodule
